//--- hw/odtc_top.v
// on-die termination control: state priority, latency timing and apb registers
//
// Behaviour
// RULE_01: termination is enabled when any of the three selection fields is non-zero.
// RULE_02: only four states exist: off, parked, nominal and write termination.
// RULE_03: priority is disabled, then write, then nominal, then parked.
// RULE_04: write termination applies in a window after each write, ignoring pin.
// RULE_05: nominal applies while registered pin is high and its field enabled.
// RULE_06: parked value is the default when enabled and nominal not active.
// RULE_07: with no active source termination stays off.
// RULE_08: every read forces termination off for a window, in every configuration.
// RULE_09: pin receiver is powered down when nominal field is zero.
// RULE_10: self refresh turns all termination off and ignores control.
// RULE_11: read window starts read latency minus two, or minus three with long preamble.
// RULE_12: read window lasts half burst plus two or three, plus one with crc.
// RULE_13: synchronous timing applies while the delay-locked loop is locked.
// RULE_14: nominal follows the pin after the turn-on and turn-off latency.
// RULE_15: pin latency is write, additive and parity latency minus two or three.
// RULE_16: read-off latency is cas, additive and parity latency minus two or three.
// RULE_17: parked returns after read-off latency plus 4 or 6, one more with long preamble.
// RULE_18: controller holds the pin high at least 4/5 or 6/7 cycles.
// RULE_19: write termination starts write latency minus two after a write.
// RULE_20: write termination ends 4 or 6 cycles later, plus crc and preamble adjustments.
// RULE_21: pin is ignored when nominal field is zero and during self refresh.
// RULE_22: resolved state is a registered two-bit select.
// RULE_23: new commands reload timers so overlapping windows extend.
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
`include "odtc_consts.vh"
module odtc_top (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire cmd_write,
  input wire cmd_read,
  input wire term_pin,
  input wire self_refresh,
  input wire dll_locked,
  output reg [1:0] term_state,
  output reg [2:0] term_value,
  output reg term_enable,
  output reg pin_rx_enable
);

  // ----------------------------------------------------------------
  // state codes
  // ----------------------------------------------------------------
  localparam [1:0] ST_OFF = 2'h0;
  localparam [1:0] ST_PARK = 2'h1;
  localparam [1:0] ST_NOMINAL = 2'h2;
  localparam [1:0] ST_WRITE = 2'h3;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  reg [2:0] nominal_term_mode_reg;
  reg [2:0] write_term_mode_reg;
  reg [2:0] parked_term_mode_reg;
  reg [5:0] cas_write_latency_reg;
  reg [5:0] additive_latency_reg;
  reg [5:0] cas_latency_reg;
  reg [2:0] parity_latency_reg;
  reg preamble2_reg;
  reg crc_reg;
  reg burst_chop_four_reg;

  wire nom_en;
  wire wr_en;
  wire park_en;
  assign nom_en = (nominal_term_mode_reg != `ODTC_RST_SEL);
  assign wr_en = (write_term_mode_reg != `ODTC_RST_SEL);
  assign park_en = (parked_term_mode_reg != `ODTC_RST_SEL);

  // ----------------------------------------------------------------
  // latency arithmetic
  // ----------------------------------------------------------------
  wire [7:0] pre_adj;
  wire [7:0] crc_adj;
  wire [7:0] pre2_adj;
  wire [7:0] write_latency;
  wire [7:0] read_latency;
  wire [7:0] pin_turn_on_latency;
  wire [7:0] pin_idx;
  wire [7:0] read_term_off_latency;
  wire [7:0] read_len;
  wire [7:0] write_term_on_latency;
  wire [7:0] write_len;

  assign pre_adj = preamble2_reg ? `ODTC_PRE2_ADJ : `ODTC_PRE1_ADJ;
  assign crc_adj = {7'h00, crc_reg};
  assign pre2_adj = {7'h00, preamble2_reg};
  assign write_latency = {2'h0, cas_write_latency_reg} + {2'h0, additive_latency_reg}
                         + {5'h00, parity_latency_reg};
  assign read_latency = {2'h0, cas_latency_reg} + {2'h0, additive_latency_reg}
                        + {5'h00, parity_latency_reg};
  // short latency settings clamp at zero instead of wrapping round
  assign pin_turn_on_latency = (write_latency > pre_adj) ?
                               write_latency - pre_adj : 8'h00; // [RULE_15]
  // turn-off uses the same figure, so one history tap serves both edges
  assign pin_idx = (pin_turn_on_latency > `ODTC_HIST_MAX) ?
                   `ODTC_HIST_MAX : pin_turn_on_latency; // [RULE_14]
  assign read_term_off_latency = (read_latency > pre_adj) ?
                                 read_latency - pre_adj : 8'h00; // [RULE_16] [RULE_11]
  // half burst plus preamble term plus crc; with fixed chop this lands at off+4/5
  assign read_len = (burst_chop_four_reg ? `ODTC_RD_HALF_CHOP : `ODTC_RD_HALF_FULL)
                    + pre_adj + crc_adj; // [RULE_12] [RULE_17]
  assign write_term_on_latency = (write_latency > `ODTC_WR_ON_ADJ) ?
                                 write_latency - `ODTC_WR_ON_ADJ : 8'h00; // [RULE_19]
  assign write_len = (burst_chop_four_reg ? `ODTC_WR_LEN_CHOP : `ODTC_WR_LEN_FULL)
                     + crc_adj + pre2_adj; // [RULE_20]

  // ----------------------------------------------------------------
  // pin sampling and nominal timing
  // ----------------------------------------------------------------
  wire pin_sync;
  wire pin_live;
  wire nominal_pin;
  reg [127:0] pin_hist_reg;

  odtc_sync2 u_pin_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(term_pin),
    .q(pin_sync)
  );

  // receiver off means the pin reads low, so a disabled field cannot raise nominal
  assign pin_live = pin_sync & nom_en & ~self_refresh; // [RULE_21] [RULE_09]

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_hist_reg <= 128'h0;
    end else begin
      pin_hist_reg <= {pin_hist_reg[126:0], pin_live};
    end
  end

  assign nominal_pin = pin_hist_reg[pin_idx[6:0]]; // [RULE_14]

  // ----------------------------------------------------------------
  // write and read windows
  // ----------------------------------------------------------------
  wire write_start;
  wire read_start;
  wire write_active;
  wire read_active;

  // commands are ignored in self refresh; writes only open a window with the field set
  assign write_start = cmd_write & wr_en & ~self_refresh; // [RULE_04]
  assign read_start = cmd_read & ~self_refresh; // [RULE_08]

  odtc_window u_write_window (
    .clk(pclk),
    .rst_n(presetn),
    .start(write_start), // [RULE_23]
    .delay(write_term_on_latency),
    .length(write_len),
    .active(write_active)
  );

  odtc_window u_read_window (
    .clk(pclk),
    .rst_n(presetn),
    .start(read_start), // [RULE_23]
    .delay(read_term_off_latency),
    .length(read_len),
    .active(read_active)
  );

  // ----------------------------------------------------------------
  // priority resolution
  // ----------------------------------------------------------------
  wire odt_mode_on;
  wire sync_mode;
  wire term_disable;
  reg [1:0] state_next;
  reg [2:0] value_next;

  assign odt_mode_on = nom_en | wr_en | park_en; // [RULE_01]
  // only synchronous timing is built; an unlocked loop leaves termination off
  assign sync_mode = dll_locked; // [RULE_13]
  assign term_disable = self_refresh | ~sync_mode | ~odt_mode_on | read_active; // [RULE_10] [RULE_08]

  always @* begin
    state_next = ST_OFF;
    if (term_disable) begin
      state_next = ST_OFF; // [RULE_03]
    end else if (write_active) begin
      state_next = ST_WRITE; // [RULE_04]
    end else if (nominal_pin & nom_en) begin
      state_next = ST_NOMINAL; // [RULE_05]
    end else if (park_en) begin
      state_next = ST_PARK; // [RULE_06]
    end else begin
      state_next = ST_OFF; // [RULE_07]
    end
  end

  always @* begin
    case (state_next) // [RULE_02]
      ST_OFF: begin
        value_next = 3'h0;
      end
      ST_PARK: begin
        value_next = parked_term_mode_reg; // [RULE_01]
      end
      ST_NOMINAL: begin
        value_next = nominal_term_mode_reg;
      end
      ST_WRITE: begin
        value_next = write_term_mode_reg;
      end
      default: begin
        value_next = 3'h0;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      term_state <= ST_OFF;
      term_value <= 3'h0;
      term_enable <= 1'b0;
      pin_rx_enable <= 1'b0;
    end else begin
      term_state <= state_next; // [RULE_22]
      term_value <= value_next;
      term_enable <= (state_next != ST_OFF);
      pin_rx_enable <= nom_en & ~self_refresh; // [RULE_09] [RULE_21]
    end
  end

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  wire acc_phase;
  wire wr_fire;
  reg addr_hit;
  reg [31:0] rd_mux;

  // one wait state: pready rises on the second access cycle, from a flop
  assign acc_phase = psel & penable & ~pready;
  assign wr_fire = psel & penable & pready & pwrite & addr_hit;

  always @* begin
    addr_hit = 1'b1;
    rd_mux = 32'h0;
    case (paddr)
      `ODTC_OFS_NOM_MODE: begin
        rd_mux = {29'h0, nominal_term_mode_reg};
      end
      `ODTC_OFS_WR_MODE: begin
        rd_mux = {29'h0, write_term_mode_reg};
      end
      `ODTC_OFS_PARK_MODE: begin
        rd_mux = {29'h0, parked_term_mode_reg};
      end
      `ODTC_OFS_LATENCY: begin
        rd_mux = {5'h00, parity_latency_reg, 2'h0, cas_latency_reg, 2'h0,
                  additive_latency_reg, 2'h0, cas_write_latency_reg};
      end
      `ODTC_OFS_CTRL: begin
        rd_mux = {29'h0, burst_chop_four_reg, crc_reg, preamble2_reg};
      end
      `ODTC_OFS_STATUS: begin
        rd_mux = {23'h0, read_active, write_active, pin_rx_enable, term_enable,
                  term_value, term_state};
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= acc_phase;
      pslverr <= acc_phase & ~addr_hit;
      prdata <= (acc_phase & ~pwrite) ? rd_mux : 32'h0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nominal_term_mode_reg <= `ODTC_RST_SEL;
      write_term_mode_reg <= `ODTC_RST_SEL;
      parked_term_mode_reg <= `ODTC_RST_SEL;
      cas_write_latency_reg <= `ODTC_RST_CWL;
      additive_latency_reg <= `ODTC_RST_AL;
      cas_latency_reg <= `ODTC_RST_CL;
      parity_latency_reg <= `ODTC_RST_PL;
      preamble2_reg <= 1'b0;
      crc_reg <= 1'b0;
      burst_chop_four_reg <= 1'b0;
    end else if (wr_fire) begin
      // status is read-only; a write to it is accepted and dropped
      case (paddr)
        `ODTC_OFS_NOM_MODE: begin
          nominal_term_mode_reg <= pwdata[`ODTC_SEL_MSB:`ODTC_SEL_LSB];
        end
        `ODTC_OFS_WR_MODE: begin
          write_term_mode_reg <= pwdata[`ODTC_SEL_MSB:`ODTC_SEL_LSB];
        end
        `ODTC_OFS_PARK_MODE: begin
          parked_term_mode_reg <= pwdata[`ODTC_SEL_MSB:`ODTC_SEL_LSB];
        end
        `ODTC_OFS_LATENCY: begin
          cas_write_latency_reg <= pwdata[`ODTC_LAT_CWL_MSB:`ODTC_LAT_CWL_LSB];
          additive_latency_reg <= pwdata[`ODTC_LAT_AL_MSB:`ODTC_LAT_AL_LSB];
          cas_latency_reg <= pwdata[`ODTC_LAT_CL_MSB:`ODTC_LAT_CL_LSB];
          parity_latency_reg <= pwdata[`ODTC_LAT_PL_MSB:`ODTC_LAT_PL_LSB];
        end
        `ODTC_OFS_CTRL: begin
          preamble2_reg <= pwdata[`ODTC_CTRL_PRE2_BIT];
          crc_reg <= pwdata[`ODTC_CTRL_CRC_BIT];
          burst_chop_four_reg <= pwdata[`ODTC_CTRL_CHOP_BIT];
        end
        default: begin
          nominal_term_mode_reg <= nominal_term_mode_reg;
        end
      endcase
    end
  end

endmodule // odtc_top

//--- hw/odtc_consts.vh
// constants for the termination control block: register map, fields, reset values, latencies
`ifndef ODTC_CONSTS_VH
`define ODTC_CONSTS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define ODTC_OFS_NOM_MODE 12'h000
`define ODTC_OFS_WR_MODE 12'h004
`define ODTC_OFS_PARK_MODE 12'h008
`define ODTC_OFS_LATENCY 12'h00C
`define ODTC_OFS_CTRL 12'h010
`define ODTC_OFS_STATUS 12'h014

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ODTC_SEL_MSB 2
`define ODTC_SEL_LSB 0
`define ODTC_LAT_CWL_MSB 5
`define ODTC_LAT_CWL_LSB 0
`define ODTC_LAT_AL_MSB 13
`define ODTC_LAT_AL_LSB 8
`define ODTC_LAT_CL_MSB 21
`define ODTC_LAT_CL_LSB 16
`define ODTC_LAT_PL_MSB 26
`define ODTC_LAT_PL_LSB 24
`define ODTC_CTRL_PRE2_BIT 0
`define ODTC_CTRL_CRC_BIT 1
`define ODTC_CTRL_CHOP_BIT 2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ODTC_RST_SEL 3'h0
`define ODTC_RST_CWL 6'h09
`define ODTC_RST_AL 6'h00
`define ODTC_RST_CL 6'h0B
`define ODTC_RST_PL 3'h0
`define ODTC_RST_CTRL 3'h0

// ----------------------------------------------------------------
// latency terms, in clock cycles
// ----------------------------------------------------------------
`define ODTC_PRE1_ADJ 8'h02
`define ODTC_PRE2_ADJ 8'h03
`define ODTC_WR_ON_ADJ 8'h02
`define ODTC_WR_LEN_CHOP 8'h04
`define ODTC_WR_LEN_FULL 8'h06
`define ODTC_RD_HALF_CHOP 8'h02
`define ODTC_RD_HALF_FULL 8'h04
`define ODTC_HIST_MAX 8'h7F

`endif

//--- hw/odtc_sync2.v
// two-flop synchroniser for one level
`timescale 1ns/10ps
module odtc_sync2 (
  input wire clk,
  input wire rst_n,
  input wire d,
  output wire q
);
  reg meta_reg;
  reg out_reg;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 1'b0;
      out_reg <= 1'b0;
    end else begin
      meta_reg <= d;
      out_reg <= meta_reg;
    end
  end
  assign q = out_reg;
endmodule // odtc_sync2

//--- hw/odtc_window.v
// delayed window timer: opens delay cycles after start, stays open for length cycles
`timescale 1ns/10ps
module odtc_window (
  input wire clk,
  input wire rst_n,
  input wire start,
  input wire [7:0] delay,
  input wire [7:0] length,
  output wire active
);
  reg [255:0] sched_reg;
  wire [255:0] run_mask;
  wire [255:0] new_mask;
  assign run_mask = ~({256{1'b1}} << length);
  assign new_mask = start ? (run_mask << delay) : 256'h0;
  // one bit per future cycle: overlapping commands merge into one longer window,
  // while commands further apart keep their own gap; delay plus length stays below 256
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sched_reg <= 256'h0;
    end else begin
      sched_reg <= {1'b0, sched_reg[255:1]} | new_mask;
    end
  end
  assign active = sched_reg[0];
endmodule // odtc_window

//--- dv/odtc_chk.sv
// assertion checker for the termination control top
`timescale 1ns/10ps
module odtc_chk (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire cmd_write,
  input wire self_refresh,
  input wire dll_locked,
  input wire [1:0] term_state,
  input wire [2:0] term_value,
  input wire term_enable,
  input wire pin_rx_enable
);
  // ------------
  // recent write commands: a later write may land inside an earlier window,
  // so write state needs some write behind it, not the latest one
  // ------------
  reg [139:0] wr_hist_reg;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) wr_hist_reg <= 140'h0;
    else wr_hist_reg <= {wr_hist_reg[138:0], cmd_write};
  end
  default clocking dcb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence apb_setup; psel && !penable; endsequence
  sequence apb_reply; penable && !pready ##1 pready; endsequence
  chk_apb_wait: assert property (apb_setup |=> apb_reply)
    else $error("apb reply not after one wait state");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  chk_err_ready: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error outside reply cycle");
  chk_idle_data: assert property (!pready |-> prdata == 32'h0)
    else $error("read data not zero outside reply");
  chk_sr_off: assert property (self_refresh |=> !term_enable && !pin_rx_enable)
    else $error("termination active in self refresh");
  chk_dll_off: assert property (!dll_locked |=> term_state == 2'h0)
    else $error("termination active while unlocked");
  chk_enable_map: assert property (term_enable == (term_state != 2'h0))
    else $error("enable disagrees with state");
  chk_off_value: assert property (term_state == 2'h0 |-> term_value == 3'h0)
    else $error("value not zero when off");
  chk_nom_rx: assert property (term_state == 2'h2 |-> pin_rx_enable)
    else $error("nominal with pin receiver down");
  chk_write_age: assert property (term_state == 2'h3 |-> |wr_hist_reg[139:1])
    else $error("write state without recent write");
endmodule // odtc_chk
bind odtc_top odtc_chk odtc_chk_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .cmd_write(cmd_write), .self_refresh(self_refresh),
  .dll_locked(dll_locked), .term_state(term_state), .term_value(term_value),
  .term_enable(term_enable), .pin_rx_enable(pin_rx_enable));

//--- dv/odtc_ctrl_model.sv
// memory controller model: command pulses and termination pin
`timescale 1ns/10ps
module odtc_ctrl_model (
  input wire pclk,
  input wire chop,
  input wire pre2,
  output reg cmd_write,
  output reg cmd_read,
  output reg term_pin
);
  initial begin
    cmd_write = 1'b0;
    cmd_read = 1'b0;
    term_pin = 1'b0;
  end
  // ------------
  // one-cycle command on the command clock
  // ------------
  task cmd(input rd);
    begin
      @(posedge pclk);
      if (rd) cmd_read <= 1'b1;
      else cmd_write <= 1'b1;
      @(posedge pclk);
      cmd_read <= 1'b0;
      cmd_write <= 1'b0;
    end
  endtask
  // pulse is stretched to the minimum hold, so a short request never makes a runt
  task pin_hold(input integer n);
    integer m;
    begin
      m = chop ? (pre2 ? 5 : 4) : (pre2 ? 7 : 6);
      if (n < m) n = m;
      @(posedge pclk);
      term_pin <= 1'b1;
      repeat (n) @(posedge pclk);
      term_pin <= 1'b0;
    end
  endtask
endmodule // odtc_ctrl_model

//--- dv/dram_termination_control_tb.sv
// self-checking bench for the termination control block
`timescale 1ns/10ps
module dram_termination_control_tb;
  reg pclk;
  reg presetn;
  reg psel;
  reg penable;
  reg pwrite;
  reg [11:0] paddr;
  reg [31:0] pwdata;
  reg self_refresh;
  reg dll_locked;
  reg [2:0] ctrl;
  reg chk_en = 1'b0;
  reg erx = 1'b0;
  reg [1:0] es = 2'h0;
  reg [2:0] ev = 3'h0;
  reg pin_h [0:255];
  reg wr_w [0:255];
  reg rd_w [0:255];
  wire [31:0] prdata;
  wire pready, pslverr, cmd_write, cmd_read, term_pin, term_enable, pin_rx_enable;
  wire [1:0] term_state;
  wire [2:0] term_value;
  integer nom = 0, wrf = 0, park = 0, cas_write_latency = 0, al = 0, cl = 0, pl = 0, lat = 0;
  integer d_w = 0, l_w = 0, d_r = 0, l_r = 0, t_p = 0, cyc = 0, k, i;
  integer tmo = 0, err_total = 0, comparisons = 0, seed = 64445;
  always #10 pclk = ~pclk;
  odtc_top odtc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmd_write(cmd_write), .cmd_read(cmd_read), .term_pin(term_pin),
    .self_refresh(self_refresh), .dll_locked(dll_locked), .term_state(term_state),
    .term_value(term_value), .term_enable(term_enable), .pin_rx_enable(pin_rx_enable));
  odtc_ctrl_model odtc_ctrl_model_inst (.pclk(pclk), .chop(ctrl[2]), .pre2(ctrl[0]),
    .cmd_write(cmd_write), .cmd_read(cmd_read), .term_pin(term_pin));
  // ------------
  // reference model: windows kept per cycle, since overlapping commands merge
  // ------------
  always @(posedge pclk) begin
    cyc = cyc + 1;
    pin_h[cyc % 256] = term_pin;
    if (cmd_write && wrf != 0 && !self_refresh)
      for (k = d_w + 1; k <= d_w + l_w; k = k + 1) wr_w[(cyc + k) % 256] = 1'b1;
    if (cmd_read && !self_refresh)
      for (k = d_r + 1; k <= d_r + l_r; k = k + 1) rd_w[(cyc + k) % 256] = 1'b1;
    if (self_refresh || !dll_locked || rd_w[cyc % 256] || nom + wrf + park == 0) es = 2'h0;
    else if (wr_w[cyc % 256]) es = 2'h3;
    else if (nom != 0 && pin_h[(cyc + 253 - t_p) % 256]) es = 2'h2;
    else es = (park != 0) ? 2'h1 : 2'h0;
    ev = (es == 2'h3) ? wrf[2:0] : (es == 2'h2) ? nom[2:0] : (es == 2'h1) ? park[2:0] : 3'h0;
    erx = nom != 0 && !self_refresh;
    wr_w[cyc % 256] = 1'b0;
    rd_w[cyc % 256] = 1'b0;
    tmo = tmo + 1;
    if (tmo == 20000) begin
      err_total = err_total + 1;
      $display("ERROR %0t timeout", $time);
      end_sim;
    end
  end
  always @(negedge pclk) begin
    if (chk_en) begin
      comparisons = comparisons + 1;
      if (term_state !== es || term_value !== ev || term_enable !== (es != 2'h0) ||
          pin_rx_enable !== erx) begin
        err_total = err_total + 1;
        $display("ERROR %0t state %0d exp %0d value %0d", $time, term_state, es, term_value);
      end
    end
  end
  task apb(input w, input [11:0] a, input [31:0] d, input [31:0] e, input ee);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      comparisons = comparisons + 1;
      if (prdata !== e || pslverr !== ee) begin
        err_total = err_total + 1;
        $display("ERROR %0t apb %h got %h exp %h", $time, a, prdata, e);
      end
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task cfg(input [2:0] m);
    begin
      chk_en = 1'b0;
      nom = m[1] ? 1 + {$random(seed)} % 7 : 0;
      wrf = m[2] ? 1 + {$random(seed)} % 7 : 0;
      park = m[0] ? 1 + {$random(seed)} % 7 : 0;
      cas_write_latency = 9 + {$random(seed)} % 4;
      al = {$random(seed)} % 4;
      pl = {$random(seed)} % 3;
      cl = 11 + {$random(seed)} % 4;
      ctrl = $random(seed);
      lat = (pl << 24) + (cl << 16) + (al << 8) + cas_write_latency;
      apb(1'b1, 12'h000, nom, 0, 1'b0);
      apb(1'b1, 12'h004, wrf, 0, 1'b0);
      apb(1'b1, 12'h008, park, 0, 1'b0);
      apb(1'b1, 12'h00C, lat, 0, 1'b0);
      apb(1'b1, 12'h010, ctrl, 0, 1'b0);
      apb(1'b0, 12'h00C, 0, lat, 1'b0);
      d_w = cas_write_latency + al + pl - 2;
      l_w = (ctrl[2] ? 4 : 6) + ctrl[1] + ctrl[0];
      d_r = cl + al + pl - (ctrl[0] ? 3 : 2);
      l_r = (ctrl[2] ? 2 : 4) + (ctrl[0] ? 3 : 2) + ctrl[1];
      t_p = cas_write_latency + al + pl - (ctrl[0] ? 3 : 2);
      repeat (40) @(posedge pclk);
      chk_en = 1'b1;
    end
  endtask
  task traffic;
    begin
      fork
        odtc_ctrl_model_inst.pin_hold({$random(seed)} % 8);
        odtc_ctrl_model_inst.cmd(1'b0);
      join
      repeat ({$random(seed)} % 30) @(posedge pclk);
      odtc_ctrl_model_inst.cmd(1'b1);
      odtc_ctrl_model_inst.cmd(1'b0);
      odtc_ctrl_model_inst.cmd(1'b0);
      fork
        odtc_ctrl_model_inst.pin_hold(6 + {$random(seed)} % 4);
        begin
          odtc_ctrl_model_inst.cmd(1'b1);
          odtc_ctrl_model_inst.cmd(1'b1);
        end
      join
      repeat (45) @(posedge pclk);
      chk_en = 1'b0;
    end
  endtask
  task end_sim;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    self_refresh = 1'b0;
    dll_locked = 1'b1;
    ctrl = 3'h0;
    for (i = 0; i < 256; i = i + 1) begin
      pin_h[i] = 1'b0;
      wr_w[i] = 1'b0;
      rd_w[i] = 1'b0;
    end
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 6; i = i + 1) apb(1'b0, {i[9:0], 2'b00}, 0, (i == 3) ? 32'h000B0009 : 0, 1'b0);
    apb(1'b1, 12'h018, 32'hFFFFFFFF, 0, 1'b1);
    apb(1'b0, 12'h018, 0, 0, 1'b1);
    apb(1'b1, 12'h014, 32'hFFFFFFFF, 0, 1'b0);
    apb(1'b0, 12'h014, 0, 0, 1'b0);
    $display("test map done");
    for (i = 0; i < 24; i = i + 1) begin
      cfg(i % 8);
      traffic;
      $display("test %0d done", i);
    end
    cfg(3'h7);
    fork
      odtc_ctrl_model_inst.pin_hold(20);
      begin
        self_refresh <= 1'b1;
        odtc_ctrl_model_inst.cmd(1'b0);
        odtc_ctrl_model_inst.cmd(1'b1);
        repeat (60) @(posedge pclk);
        self_refresh <= 1'b0;
      end
    join
    dll_locked <= 1'b0;
    odtc_ctrl_model_inst.pin_hold(8);
    repeat (30) @(posedge pclk);
    dll_locked <= 1'b1;
    repeat (40) @(posedge pclk);
    $display("test low power done");
    end_sim;
  end
endmodule // dram_termination_control_tb
